// File: core/relay_irq_consts.svh
`ifndef RELAY_IRQ_CONSTS_SVH
`define RELAY_IRQ_CONSTS_SVH

// =====================================================================
// register map (byte addresses, chosen)
`define REG_FLAGS_ADDR      8'h00
`define REG_MASK_ADDR       8'h04
`define REG_ADDR_LSB        2
`define REG_ADDR_MSB        7

// =====================================================================
// field layout: writable bits of mask and flags
`define RELAY_VALID_BITS    32'h0fdf0fdf
`define RELAY_MASK_RESET    32'h00000000
`define RELAY_FLAGS_RESET   32'h00000000

// =====================================================================
// bit positions
`define BIT_M0_NO_CARRIER   27
`define BIT_M0_RETRY_TO     24
`define BIT_FWD_OVF         23
`define BIT_M0_ALERT        22
`define BIT_M0_RESIDUAL     20
`define BIT_M0_CRC          16
`define BIT_M1_NO_CARRIER   11
`define BIT_M1_RETRY_TO     8
`define BIT_REV_OVF         7
`define BIT_M1_ALERT        6
`define BIT_M1_RESIDUAL     4
`define BIT_M1_CRC          0

// =====================================================================
// axi response codes
`define AXI_RESP_OKAY       2'b00
`define AXI_RESP_SLVERR     2'b10

`endif

// File: core/relay_irq_pkg.sv
package relay_irq_pkg;

    typedef struct packed {
        logic [31:0] flags;
        logic [31:0] mask;
        logic        aw_done;
        logic        w_done;
        logic [7:0]  aw_addr;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        irq;
    } relay_state_t;

    typedef struct packed {
        logic        wr_en;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } reg_write_t;

endpackage

// File: core/relay_irq_merge.sv
`timescale 1ns/10ps
`default_nettype none
`include "relay_irq_consts.svh"

module relay_irq_merge (
    input  wire logic [31:0] flags,
    input  wire logic [31:0] mask,
    output logic             irq_pending
);
    // combinational only; top registers the result
    assign irq_pending = |(flags & mask & `RELAY_VALID_BITS);
endmodule // relay_irq_merge

`default_nettype wire

// File: core/relay_status_irq_mask.sv
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "relay_irq_consts.svh"

module relay_status_irq_mask (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // event pulses from the mac and relay logic
    input  wire logic [3:0]  m0_tx_events,
    input  wire logic [3:0]  m1_tx_events,
    input  wire logic        fwd_fifo_overflow,
    input  wire logic        rev_fifo_overflow,
    input  wire logic        m0_overflow_alert,
    input  wire logic        m1_overflow_alert,
    input  wire logic [4:0]  m0_rx_events,
    input  wire logic [4:0]  m1_rx_events,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             relay_irq
);

    relay_irq_pkg::relay_state_t state;
    relay_irq_pkg::relay_state_t next_state;
    relay_irq_pkg::reg_write_t   wr;
    logic [31:0]                 events;
    logic                        irq_pending;

    // ==================================================================
    // helpers
    function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] r);
        return a[`REG_ADDR_MSB:`REG_ADDR_LSB] == r[`REG_ADDR_MSB:`REG_ADDR_LSB];
    endfunction

    // ==================================================================
    // event vector, laid out on the mask positions
    always_comb begin
        events = 32'h00000000;
        events[`BIT_M0_NO_CARRIER:`BIT_M0_RETRY_TO] = m0_tx_events;
        events[`BIT_M1_NO_CARRIER:`BIT_M1_RETRY_TO] = m1_tx_events;
        events[`BIT_FWD_OVF]                        = fwd_fifo_overflow;
        events[`BIT_REV_OVF]                        = rev_fifo_overflow;
        events[`BIT_M0_ALERT]                       = m0_overflow_alert;
        events[`BIT_M1_ALERT]                       = m1_overflow_alert;
        events[`BIT_M0_RESIDUAL:`BIT_M0_CRC]        = m0_rx_events;
        events[`BIT_M1_RESIDUAL:`BIT_M1_CRC]        = m1_rx_events;
    end

    // fed from the registered flags and mask: no loop back through next_state
    relay_irq_merge u_merge (
        .flags       (state.flags),
        .mask        (state.mask),
        .irq_pending (irq_pending)
    );

    // ==================================================================
    // next state
    always_comb begin
        next_state = state;
        wr         = '0;

        // address and data may arrive in either order
        if (s_axi_awvalid && !state.aw_done) begin
            next_state.aw_done = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state.w_done) begin
            next_state.w_done = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end

        if (state.aw_done && state.w_done && !state.bvalid) begin
            wr.wr_en           = 1'b1;
            wr.addr            = state.aw_addr;
            wr.data            = state.w_data;
            wr.strb            = state.w_strb;
            next_state.aw_done = 1'b0;
            next_state.w_done  = 1'b0;
            next_state.bvalid  = 1'b1;
            if (addr_is(wr.addr, `REG_FLAGS_ADDR) || addr_is(wr.addr, `REG_MASK_ADDR)) begin
                next_state.bresp = `AXI_RESP_OKAY;
            end else begin
                next_state.bresp = `AXI_RESP_SLVERR;
            end
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end

        // mask: plain read/write, reserved bits held at zero
        if (wr.wr_en && addr_is(wr.addr, `REG_MASK_ADDR)) begin
            next_state.mask = apply_strb(state.mask, wr.data, wr.strb)
                              & `RELAY_VALID_BITS;
        end

        // flags: write one to clear, a same-cycle event wins
        next_state.flags = state.flags;
        if (wr.wr_en && addr_is(wr.addr, `REG_FLAGS_ADDR)) begin
            next_state.flags = state.flags & ~apply_strb(32'h00000000, wr.data, wr.strb);
        end
        next_state.flags = (next_state.flags | events) & `RELAY_VALID_BITS;

        // read channel
        if (s_axi_arvalid && !state.rvalid) begin
            next_state.rvalid = 1'b1;
            if (addr_is(s_axi_araddr, `REG_FLAGS_ADDR)) begin
                next_state.rdata = state.flags;
                next_state.rresp = `AXI_RESP_OKAY;
            end else if (addr_is(s_axi_araddr, `REG_MASK_ADDR)) begin
                next_state.rdata = state.mask;
                next_state.rresp = `AXI_RESP_OKAY;
            end else begin
                next_state.rdata = 32'h00000000;
                next_state.rresp = `AXI_RESP_SLVERR;
            end
        end else if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end

        // irq one cycle behind flags/mask so the output is a flop
        next_state.irq = irq_pending;
    end

    // ==================================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state       <= '0;
            state.mask  <= `RELAY_MASK_RESET;
            state.flags <= `RELAY_FLAGS_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ==================================================================
    // outputs; awready and wready are the inverted done bits, arready the inverted rvalid
    assign s_axi_awready = !state.aw_done;
    assign s_axi_wready  = !state.w_done;
    assign s_axi_bvalid  = state.bvalid;
    assign s_axi_bresp   = state.bresp;
    assign s_axi_arready = !state.rvalid;
    assign s_axi_rvalid  = state.rvalid;
    assign s_axi_rdata   = state.rdata;
    assign s_axi_rresp   = state.rresp;
    assign relay_irq     = state.irq;

    // ==================================================================
    // checks
    a_mask_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.mask & ~`RELAY_VALID_BITS) == 32'h00000000)
        else $error("reserved mask bit set");

    a_mask_reset_zero: assert property (@(posedge aclk)
        $rose(aresetn) |-> state.mask == 32'h00000000)
        else $error("mask not zero after reset");

    a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.flags & state.mask) != 32'h00000000 |=> relay_irq)
        else $error("irq missing for enabled flag");

    a_irq_exact: assert property (@(posedge aclk) disable iff (!aresetn)
        relay_irq == $past(|(state.flags & state.mask)))
        else $error("irq not formed from flags and mask");

    a_irq_masked_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.mask == 32'h00000000) |=> !relay_irq)
        else $error("irq with all masked");

    a_flag_tx_m0_nc: assert property (@(posedge aclk) disable iff (!aresetn)
        m0_tx_events[3] |=> state.flags[`BIT_M0_NO_CARRIER])
        else $error("m0 no carrier flag lost");

    a_flag_rx_m1_crc: assert property (@(posedge aclk) disable iff (!aresetn)
        m1_rx_events[0] |=> state.flags[`BIT_M1_CRC])
        else $error("m1 crc flag lost");

    a_flag_fifo_rev: assert property (@(posedge aclk) disable iff (!aresetn)
        rev_fifo_overflow |=> state.flags[`BIT_REV_OVF])
        else $error("reverse overflow flag lost");

    a_flag_alert_m0: assert property (@(posedge aclk) disable iff (!aresetn)
        m0_overflow_alert |=> state.flags[`BIT_M0_ALERT])
        else $error("m0 alert flag lost");

    a_flag_fifo_fwd: assert property (@(posedge aclk) disable iff (!aresetn)
        fwd_fifo_overflow |=> state.flags[`BIT_FWD_OVF])
        else $error("forward overflow flag lost");

    a_flag_alert_m1: assert property (@(posedge aclk) disable iff (!aresetn)
        m1_overflow_alert |=> state.flags[`BIT_M1_ALERT])
        else $error("alert flag lost");

    a_flag_rx_m0: assert property (@(posedge aclk) disable iff (!aresetn)
        m0_rx_events[0] |=> state.flags[`BIT_M0_CRC])
        else $error("m0 crc flag lost");

    a_flag_tx_m1: assert property (@(posedge aclk) disable iff (!aresetn)
        m1_tx_events[3] |=> state.flags[`BIT_M1_NO_CARRIER])
        else $error("m1 no carrier flag lost");

    a_flag_tx_m0: assert property (@(posedge aclk) disable iff (!aresetn)
        m0_tx_events[0] |=> state.flags[`BIT_M0_RETRY_TO])
        else $error("m0 retry flag lost");

    a_flag_rx_m1: assert property (@(posedge aclk) disable iff (!aresetn)
        m1_rx_events[4] |=> state.flags[`BIT_M1_RESIDUAL])
        else $error("m1 residual flag lost");

    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.aw_done && state.w_done && !state.bvalid) |=> s_axi_bvalid)
        else $error("write not answered");

    a_flags_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.flags & ~`RELAY_VALID_BITS) == 32'h00000000)
        else $error("reserved flag bit set");

    a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.flags[`BIT_M0_CRC] && !wr.wr_en) |=> state.flags[`BIT_M0_CRC])
        else $error("flag dropped without a clear");

    a_enable_m0_tx: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.flags[`BIT_M0_NO_CARRIER] && state.mask[`BIT_M0_NO_CARRIER]) |=> relay_irq)
        else $error("m0 tx enable ignored");

    a_enable_m1_tx: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.flags[`BIT_M1_RETRY_TO] && state.mask[`BIT_M1_RETRY_TO]) |=> relay_irq)
        else $error("m1 tx enable ignored");

    a_enable_fifo: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.flags[`BIT_FWD_OVF] && state.mask[`BIT_FWD_OVF]) |=> relay_irq)
        else $error("fifo enable ignored");

    a_enable_alert: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.flags[`BIT_M1_ALERT] && state.mask[`BIT_M1_ALERT]) |=> relay_irq)
        else $error("alert enable ignored");

    a_enable_m0_rx: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.flags[`BIT_M0_RESIDUAL] && state.mask[`BIT_M0_RESIDUAL]) |=> relay_irq)
        else $error("m0 rx enable ignored");

    a_enable_m1_rx: assert property (@(posedge aclk) disable iff (!aresetn)
        (state.flags[`BIT_M1_CRC] && state.mask[`BIT_M1_CRC]) |=> relay_irq)
        else $error("m1 rx enable ignored");

    a_mask_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr.wr_en && addr_is(wr.addr, `REG_MASK_ADDR) && wr.strb == 4'hf)
            |=> state.mask == ($past(wr.data) & `RELAY_VALID_BITS))
        else $error("mask write lost");

    a_mask_held: assert property (@(posedge aclk) disable iff (!aresetn)
        !wr.wr_en |=> $stable(state.mask))
        else $error("mask changed without a write");

    a_read_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read not answered");

    a_arready_low: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while one is open");

    a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");

    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");

    a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && !addr_is(s_axi_araddr, `REG_FLAGS_ADDR)
            && !addr_is(s_axi_araddr, `REG_MASK_ADDR))
            |=> s_axi_rdata == 32'h00000000)
        else $error("unmapped read not zero");

endmodule // relay_status_irq_mask

`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "relay_irq_consts.svh"

module tb_top;
    logic        aclk, aresetn, relay_irq;
    logic [31:0] ev;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [31:0] mask_m, flags_m;
    int          err_count, checks;

    // events travel as one word laid out like the mask, so bit b drives flag b
    relay_status_irq_mask relay_status_irq_mask_i (
        .aclk, .aresetn,
        .m0_tx_events(ev[27:24]), .m1_tx_events(ev[11:8]),
        .fwd_fifo_overflow(ev[23]), .rev_fifo_overflow(ev[7]),
        .m0_overflow_alert(ev[22]), .m1_overflow_alert(ev[6]),
        .m0_rx_events(ev[20:16]), .m1_rx_events(ev[4:0]),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .relay_irq);

    // ==========================================
    // compares
    task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_resp(input string n, input logic [1:0] e, input logic [1:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic check_irq(input logic e);
        @(negedge aclk);
        checks++;
        if (relay_irq !== e) begin
            err_count++;
            $display("CHECK FAILED relay_irq expected %b seen %b", e, relay_irq);
        end
    endtask

    // ==========================================
    // bus tasks: handshakes noted at negedge, released at the edge they complete
    function automatic logic [1:0] exp_resp(input logic [7:0] a);
        return (a == `REG_FLAGS_ADDR || a == `REG_MASK_ADDR) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    endfunction
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ta, tw, tb;
        logic [1:0] r;
        logic [31:0] m;
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= d & `RELAY_VALID_BITS; s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid & s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
            n++;
        end while (!tb && n < 100);
        check_word("bvalid", 32'h00000001, {31'h0, tb});
        check_resp("bresp", exp_resp(a), r);
        for (int i = 0; i < 4; i++) m[i*8 +: 8] = {8{s[i]}};
        if (a == `REG_MASK_ADDR) mask_m = (mask_m & ~m) | (d & m & `RELAY_VALID_BITS);
        if (a == `REG_FLAGS_ADDR) flags_m = flags_m & ~(d & m);
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid & s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
            n++;
        end while (!tr && n < 100);
        check_word("rvalid", 32'h00000001, {31'h0, tr});
        check_resp("rresp", exp_resp(a), r);
        check_word("rdata", e, d);
    endtask
    task automatic pulse(input logic [31:0] v);
        @(posedge aclk);
        ev <= v;
        @(posedge aclk);
        ev <= 32'h00000000;
        flags_m = flags_m | (v & `RELAY_VALID_BITS);
        @(posedge aclk);
    endtask
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        mask_m = `RELAY_MASK_RESET;
        flags_m = `RELAY_FLAGS_RESET;
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================
    // stimulus
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end
    initial begin
        err_count = 0; checks = 0; aresetn = 1'b0; ev = 32'h00000000;
        s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'h0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
        mask_m = 32'h00000000; flags_m = 32'h00000000;
        void'($urandom(92689));
        do_reset();
        reg_rd(`REG_MASK_ADDR, 32'h00000000);
        check_irq(1'b0);
        reg_wr(`REG_MASK_ADDR, 32'hffffffff, 4'hf);
        reg_rd(`REG_MASK_ADDR, mask_m);
        reg_wr(8'h08, 32'h0000ffff, 4'hf);
        reg_rd(8'h08, 32'h00000000);
        reg_rd(`REG_MASK_ADDR, mask_m);
        $display("test reset and access done");
        for (int b = 0; b < 32; b++) begin
            reg_wr(`REG_FLAGS_ADDR, 32'hffffffff, 4'hf);
            reg_wr(`REG_MASK_ADDR, ~(32'h1 << b), 4'hf);
            pulse(32'h1 << b);
            check_irq(1'b0);
            reg_rd(`REG_FLAGS_ADDR, flags_m);
            reg_wr(`REG_MASK_ADDR, 32'h1 << b, 4'hf);
            check_irq(flags_m[b]);
        end
        $display("test per bit done");
        repeat (30) begin
            reg_wr(`REG_MASK_ADDR, $urandom(), 4'($urandom()));
            pulse($urandom() & $urandom());
            reg_rd(`REG_MASK_ADDR, mask_m);
            reg_rd(`REG_FLAGS_ADDR, flags_m);
            check_irq(|(flags_m & mask_m));
            reg_wr(`REG_FLAGS_ADDR, $urandom(), 4'($urandom()));
            check_irq(|(flags_m & mask_m));
        end
        $display("test random done");
        do_reset();
        reg_rd(`REG_MASK_ADDR, 32'h00000000);
        reg_rd(`REG_FLAGS_ADDR, 32'h00000000);
        check_irq(1'b0);
        $display("test second reset done");
        report_and_stop();
    end
endmodule // tb_top

`default_nettype wire
